// [src/bhiw_regs.sv]
// bridge header registers and io window decode behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none

module bhiw_regs
   import bhiw_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // io forwarding decision
   input wire bhiw_io_req_t io_req,
   output bhiw_io_fwd_t io_fwd
);

   // ------------------------------------------------------------
   // bus front end
   // ------------------------------------------------------------
   logic accept;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rd_mux;
   logic wr_en;

   // zero wait states: every transfer ends in its first data cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign accept = hsel && htrans[1] && hready;
   assign wr_en = wr_pend_r;

   // remember a write address phase for the following data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= accept && hwrite;
         if (accept) begin
            wr_addr_r <= haddr[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [7:0] cache_line_size_scratch_r;
   logic [7:0] upstream_bus_number_r;
   logic [7:0] downstream_bus_number_r;
   logic [7:0] highest_bus_behind_r;
   bhiw_io_addressing_capability_t io_addressing_capability_r;
   logic [3:0] io_window_low_r;
   logic [3:0] io_window_high_r;

   // scratch and bus numbers: stored only, nothing downstream reads them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cache_line_size_scratch_r <= RST_CLS;
         upstream_bus_number_r <= RST_BUS;
         downstream_bus_number_r <= RST_BUS;
         highest_bus_behind_r <= RST_BUS;
      end else if (wr_en) begin
         if (wr_addr_r == ADDR_CLS) begin
            cache_line_size_scratch_r <= hwdata[7:0];
         end
         if (wr_addr_r == ADDR_UP_BUS) begin
            upstream_bus_number_r <= hwdata[7:0];
         end
         if (wr_addr_r == ADDR_DN_BUS) begin
            downstream_bus_number_r <= hwdata[7:0];
         end
         if (wr_addr_r == ADDR_HI_BUS) begin
            highest_bus_behind_r <= hwdata[7:0];
         end
      end
   end

   // io window bytes; reserved bits and the limit copy are not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_addressing_capability_r <= thirty_two_bit_io;
         io_window_low_r <= RST_IO_LOW;
         io_window_high_r <= RST_IO_HIGH;
      end else if (wr_en) begin
         if (wr_addr_r == ADDR_IO_LOW) begin
            io_addressing_capability_r <=
               bhiw_io_addressing_capability_t'(hwdata[IO_CAP_BIT]);
            io_window_low_r <= hwdata[7:4];
         end
         if (wr_addr_r == ADDR_IO_HIGH) begin
            io_window_high_r <= hwdata[7:4];
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // read-only words are constants; writes to them fall through above
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         ADDR_CLS: rd_mux = {24'h000000, cache_line_size_scratch_r};
         ADDR_UP_LAT: rd_mux = {24'h000000, VAL_LAT};
         ADDR_HDR: rd_mux = {24'h000000, VAL_HDR};
         ADDR_SELFTEST: rd_mux = {24'h000000, VAL_SELFTEST};
         ADDR_UNUSED0: rd_mux = VAL_UNUSED;
         ADDR_UNUSED1: rd_mux = VAL_UNUSED;
         ADDR_UP_BUS: rd_mux = {24'h000000, upstream_bus_number_r};
         ADDR_DN_BUS: rd_mux = {24'h000000, downstream_bus_number_r};
         ADDR_HI_BUS: rd_mux = {24'h000000, highest_bus_behind_r};
         ADDR_DN_LAT: rd_mux = {24'h000000, VAL_LAT};
         ADDR_IO_LOW: rd_mux = {24'h000000, io_window_low_r, 3'h0,
            io_addressing_capability_r};
         ADDR_IO_HIGH: rd_mux = {24'h000000, io_window_high_r, 3'h0,
            io_addressing_capability_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data is sampled at the address phase; safe because a single
   // transfer master never overlaps a write data phase with a read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (accept && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // io window decode
   // ------------------------------------------------------------
   logic win_hit;
   logic upper_ok;

   // in 16-bit mode the upper address half is not decoded; in 32-bit mode
   // the upper base and limit halves are zero, so the upper half must be
   assign upper_ok = (io_addressing_capability_r == sixteen_bit_io) ||
      (io_req.addr[31:16] == 16'h0000);
   // inclusive compare on A15:12; base above limit never matches
   assign win_hit = upper_ok &&
      (io_req.addr[15:12] >= io_window_low_r) &&
      (io_req.addr[15:12] <= io_window_high_r);

   // decision is registered, one cycle after the request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_fwd <= '0;
      end else begin
         io_fwd.valid <= io_req.valid;
         io_fwd.hit <= io_req.valid && win_hit;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_cls_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_en && wr_addr_r == ADDR_CLS |=>
      cache_line_size_scratch_r == $past(hwdata[7:0]))
      else $error("cache line byte not stored");

   chk_hdr_const: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_HDR |=>
      hrdata == 32'h0000_0001)
      else $error("header type read wrong");

   chk_selftest_zero: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_SELFTEST |=>
      hrdata == 32'h0000_0000)
      else $error("self-test byte not zero");

   chk_latency_zero: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && (haddr[7:0] == ADDR_UP_LAT ||
      haddr[7:0] == ADDR_DN_LAT) |=> hrdata == 32'h0000_0000)
      else $error("latency timer not zero");

   chk_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && !hwrite && (haddr[7:0] == ADDR_UNUSED0 ||
      haddr[7:0] == ADDR_UNUSED1) |=> hrdata == 32'h0000_0000)
      else $error("unused base word not zero");

   chk_bus_numbers: assert property (@(posedge hclk)
      disable iff (!hresetn)
      wr_en && wr_addr_r == ADDR_UP_BUS ##1 !wr_en |->
      upstream_bus_number_r == $past(hwdata[7:0]))
      else $error("upstream bus number lost");

   chk_dn_bus: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_en && wr_addr_r == ADDR_DN_BUS |=>
      downstream_bus_number_r == $past(hwdata[7:0]))
      else $error("downstream bus number not stored");

   chk_hi_bus: assert property (@(posedge hclk) disable iff (!hresetn)
      !(wr_en && wr_addr_r == ADDR_HI_BUS) |=>
      $stable(highest_bus_behind_r))
      else $error("highest bus changed without write");

   chk_cap_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_en && wr_addr_r == ADDR_IO_LOW |=>
      io_addressing_capability_r == $past(hwdata[0]))
      else $error("capability bit not stored");

   chk_limit_mirror: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_IO_HIGH |=>
      hrdata[0] == io_addressing_capability_r &&
      hrdata[3:1] == 3'h0)
      else $error("limit bit zero does not mirror");

   chk_base_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_en && wr_addr_r == ADDR_IO_LOW |=>
      io_window_low_r == $past(hwdata[7:4]))
      else $error("io base not stored");

   chk_limit_write: assert property (@(posedge hclk)
      disable iff (!hresetn)
      wr_en && wr_addr_r == ADDR_IO_HIGH |=>
      io_window_high_r == $past(hwdata[7:4]))
      else $error("io limit not stored");

   chk_fwd_decide: assert property (@(posedge hclk) disable iff (!hresetn)
      io_req.valid && upper_ok &&
      io_req.addr[15:12] == io_window_low_r &&
      io_window_low_r <= io_window_high_r |=> io_fwd.hit)
      else $error("base address not forwarded");

   chk_empty_window: assert property (@(posedge hclk)
      disable iff (!hresetn)
      io_window_low_r > io_window_high_r |=> !io_fwd.hit)
      else $error("hit in an empty window");

   // ------------------------------------------------------------
   // read-back, hold and decode edge checks
   // ------------------------------------------------------------
   // read-back uses $past so a late write to another word cannot mask it;
   // hold checks catch a stray write enable decoding the wrong address
   chk_upper_zero: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] != ADDR_UNUSED0 &&
      haddr[7:0] != ADDR_UNUSED1 |=> hrdata[31:8] == 24'h000000)
      else $error("byte register upper bits not zero");

   chk_cls_read: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_CLS |=>
      hrdata[7:0] == $past(cache_line_size_scratch_r))
      else $error("cache line byte read wrong");

   chk_cls_hold: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !(wr_en && wr_addr_r == ADDR_CLS) |=>
      $stable(cache_line_size_scratch_r))
      else $error("cache line byte changed without write");

   chk_up_read: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_UP_BUS |=>
      hrdata[7:0] == $past(upstream_bus_number_r))
      else $error("upstream bus number read wrong");

   chk_up_hold: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !(wr_en && wr_addr_r == ADDR_UP_BUS) |=>
      $stable(upstream_bus_number_r))
      else $error("upstream bus number changed without write");

   chk_dn_read: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_DN_BUS |=>
      hrdata[7:0] == $past(downstream_bus_number_r))
      else $error("downstream bus number read wrong");

   chk_dn_hold: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !(wr_en && wr_addr_r == ADDR_DN_BUS) |=>
      $stable(downstream_bus_number_r))
      else $error("downstream bus number changed without write");

   chk_hi_read: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_HI_BUS |=>
      hrdata[7:0] == $past(highest_bus_behind_r))
      else $error("highest bus number read wrong");

   chk_low_read: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_IO_LOW |=>
      hrdata[7:0] == {$past(io_window_low_r), 3'h0,
      $past(io_addressing_capability_r)}) else $error("io base read wrong");

   chk_low_hold: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !(wr_en && wr_addr_r == ADDR_IO_LOW) |=>
      $stable(io_addressing_capability_r) && $stable(io_window_low_r))
      else $error("io base changed without write");

   chk_high_read: assert property (@(posedge hclk)
      disable iff (!hresetn)
      accept && !hwrite && haddr[7:0] == ADDR_IO_HIGH |=>
      hrdata[7:4] == $past(io_window_high_r))
      else $error("io limit read wrong");

   chk_high_hold: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !(wr_en && wr_addr_r == ADDR_IO_HIGH) |=>
      $stable(io_window_high_r))
      else $error("io limit changed without write");

   chk_fwd_valid: assert property (@(posedge hclk)
      disable iff (!hresetn)
      io_req.valid |=>
      io_fwd.valid)
      else $error("forwarding decision missing");

   chk_fwd_idle: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !io_req.valid |=>
      !io_fwd.valid && !io_fwd.hit)
      else $error("forwarding decision without request");

   chk_fwd_below: assert property (@(posedge hclk)
      disable iff (!hresetn)
      io_req.valid && io_req.addr[15:12] < io_window_low_r |=>
      !io_fwd.hit)
      else $error("hit below the io base");

   chk_fwd_above: assert property (@(posedge hclk)
      disable iff (!hresetn)
      io_req.valid && io_req.addr[15:12] > io_window_high_r |=>
      !io_fwd.hit)
      else $error("hit above the io limit");

   chk_fwd_upper: assert property (@(posedge hclk)
      disable iff (!hresetn)
      io_req.valid && io_addressing_capability_r == thirty_two_bit_io &&
      io_req.addr[31:16] != 16'h0000 |=> !io_fwd.hit)
      else $error("hit with upper address bits set");

endmodule

`default_nettype wire

// [src/bhiw_pkg.sv]
// shared constants and carrier types for the bridge header / io window bank
package bhiw_pkg;

   // ------------------------------------------------------------
   // register indices (word index; byte address is four times it)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_CLS = 8'h0c;
   localparam logic [7:0] IDX_UP_LAT = 8'h0d;
   localparam logic [7:0] IDX_HDR = 8'h0e;
   localparam logic [7:0] IDX_SELFTEST = 8'h0f;
   localparam logic [7:0] IDX_UNUSED0 = 8'h10;
   localparam logic [7:0] IDX_UNUSED1 = 8'h14;
   localparam logic [7:0] IDX_UP_BUS = 8'h18;
   localparam logic [7:0] IDX_DN_BUS = 8'h19;
   localparam logic [7:0] IDX_HI_BUS = 8'h1a;
   localparam logic [7:0] IDX_DN_LAT = 8'h1b;
   localparam logic [7:0] IDX_IO_LOW = 8'h1c;
   localparam logic [7:0] IDX_IO_HIGH = 8'h1d;

   // ------------------------------------------------------------
   // byte addresses on the bus
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CLS = IDX_CLS << 2;
   localparam logic [7:0] ADDR_UP_LAT = IDX_UP_LAT << 2;
   localparam logic [7:0] ADDR_HDR = IDX_HDR << 2;
   localparam logic [7:0] ADDR_SELFTEST = IDX_SELFTEST << 2;
   localparam logic [7:0] ADDR_UNUSED0 = IDX_UNUSED0 << 2;
   localparam logic [7:0] ADDR_UNUSED1 = IDX_UNUSED1 << 2;
   localparam logic [7:0] ADDR_UP_BUS = IDX_UP_BUS << 2;
   localparam logic [7:0] ADDR_DN_BUS = IDX_DN_BUS << 2;
   localparam logic [7:0] ADDR_HI_BUS = IDX_HI_BUS << 2;
   localparam logic [7:0] ADDR_DN_LAT = IDX_DN_LAT << 2;
   localparam logic [7:0] ADDR_IO_LOW = IDX_IO_LOW << 2;
   localparam logic [7:0] ADDR_IO_HIGH = IDX_IO_HIGH << 2;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int IO_CAP_BIT = 0;
   localparam int IO_ADDR_LSB = 4;
   localparam logic [7:0] RST_CLS = 8'h00;
   localparam logic [7:0] VAL_HDR = 8'h01;
   localparam logic [7:0] VAL_SELFTEST = 8'h00;
   localparam logic [7:0] VAL_LAT = 8'h00;
   localparam logic [31:0] VAL_UNUSED = 32'h0000_0000;
   localparam logic [7:0] RST_BUS = 8'h00;
   localparam logic io_addressing_capability_rst = 1'b1;
   localparam logic [3:0] RST_IO_LOW = 4'hf;
   localparam logic [3:0] RST_IO_HIGH = 4'h0;
   localparam logic [11:0] IO_LIMIT_FILL = 12'hfff;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // capability codes
   typedef enum logic {
      sixteen_bit_io = 1'b0,
      thirty_two_bit_io = 1'b1
   } bhiw_io_addressing_capability_t;

   // io transaction offered for a forwarding decision
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } bhiw_io_req_t;

   // forwarding decision, one cycle after the request
   typedef struct packed {
      logic valid;
      logic hit;
   } bhiw_io_fwd_t;

endpackage

// [verification/bhiw_tb.sv]
// self-checking bench for the bridge header and io window register bank
`timescale 1ns/1ps
`default_nettype none

module tb
   import bhiw_pkg::*;
();
   // ------------------------------------------------------------
   // signals, model state and bookkeeping
   // ------------------------------------------------------------
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, seed, rq;
   bhiw_io_req_t io_req;
   bhiw_io_fwd_t io_fwd;
   int err_count, check_count, cycles;
   int m_cls, m_ub, m_db, m_hb, m_cap, m_base, m_lim;
   logic [7:0] addrs [13] = '{ADDR_CLS, ADDR_UP_LAT, ADDR_HDR, ADDR_SELFTEST,
      ADDR_UNUSED0, ADDR_UNUSED1, ADDR_UP_BUS, ADDR_DN_BUS, ADDR_HI_BUS,
      ADDR_DN_LAT, ADDR_IO_LOW, ADDR_IO_HIGH, 8'h44};

   // single slave, so its ready out is the bus ready
   bhiw_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .io_req(io_req), .io_fwd(io_fwd));

   // 50 mhz clock
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // hang guard, well above the thousand or so cycles the run needs
   always @(posedge hclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         end_of_test;
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic end_of_test;
      if (err_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
      check_count = check_count + 1;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         err_count = err_count + 1;
      end
   endtask

   task automatic model_rst;
      m_cls = 0; m_ub = 0; m_db = 0; m_hb = 0;
      m_cap = 1; m_base = 15; m_lim = 0;
   endtask

   // what software should see at each byte address
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         ADDR_CLS: return m_cls;
         ADDR_HDR: return 32'h0000_0001;
         ADDR_UP_BUS: return m_ub;
         ADDR_DN_BUS: return m_db;
         ADDR_HI_BUS: return m_hb;
         ADDR_IO_LOW: return m_base * 16 + m_cap;
         ADDR_IO_HIGH: return m_lim * 16 + m_cap;
         default: return 32'h0000_0000;
      endcase
   endfunction

   // ready is sampled mid-cycle, so the edge's own updates never race us
   task automatic wait_rdy(output logic [31:0] d);
      int n;
      logic r;
      n = 0;
      do begin
         @(negedge hclk);
         r = hreadyout;
         d = hrdata;
         @(posedge hclk);
         n++;
      end while (r !== 1'b1 && n < 50);
      if (r !== 1'b1) begin
         err_count = err_count + 1;
         end_of_test;
      end
   endtask

   // one single ahb-lite transfer; upper address bits are noise on purpose
   task automatic ahb(input logic wr, logic [7:0] a, logic [31:0] d);
      logic [31:0] r, junk;
      r = xs();
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {r[23:0], a};
      hwrite <= wr;
      wait_rdy(junk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(rq);
      if (wr) begin
         case (a)
            ADDR_CLS: m_cls = d[7:0];
            ADDR_UP_BUS: m_ub = d[7:0];
            ADDR_DN_BUS: m_db = d[7:0];
            ADDR_HI_BUS: m_hb = d[7:0];
            ADDR_IO_LOW: begin
               m_cap = d[0];
               m_base = d[7:4];
            end
            ADDR_IO_HIGH: m_lim = d[7:4];
            default: ;
         endcase
      end
   endtask

   task automatic read_all;
      foreach (addrs[i]) begin
         ahb(1'b0, addrs[i], xs());
         chk("hrdata", exp_rd(addrs[i]), rq);
      end
   endtask

   // one forwarding request at the given nibble; decision stands one cycle
   task automatic io_try(input logic [3:0] nib);
      logic [31:0] r, a;
      logic e;
      r = xs();
      a = {(r[3] ? r[31:16] : 16'h0000), nib, r[11:0]};
      e = (nib >= m_base && nib <= m_lim && (m_cap == 0 || a[31:16] == 0));
      io_req <= '{valid: 1'b1, addr: a};
      @(posedge hclk);
      io_req.valid <= 1'b0;
      @(negedge hclk);
      chk("fwd_valid", 32'h1, {31'h0, io_fwd.valid});
      chk("fwd_hit", {31'h0, e}, {31'h0, io_fwd.hit});
      @(negedge hclk);
      chk("fwd_idle", 32'h0, {31'h0, io_fwd.valid});
      @(posedge hclk);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      io_req = '0;
      err_count = 0;
      check_count = 0;
      cycles = 0;
      seed = 32'd80891;
      model_rst;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("hresp", 32'h0, {31'h0, hresp});
      // reset values, then random writes everywhere incl. read-only words
      read_all;
      repeat (4) begin
         foreach (addrs[i]) ahb(1'b1, addrs[i], xs());
         read_all;
      end
      // both addressing modes, limit byte must follow each
      ahb(1'b1, ADDR_IO_HIGH, 32'h0000_00f1);
      ahb(1'b1, ADDR_IO_LOW, 32'h0000_00f0);
      read_all;
      ahb(1'b1, ADDR_IO_LOW, 32'h0000_0051);
      read_all;
      // window edges, including empty windows where base is above limit
      repeat (40) begin
         ahb(1'b1, ADDR_IO_LOW, xs());
         ahb(1'b1, ADDR_IO_HIGH, xs());
         io_try(m_base);
         io_try(m_lim);
         io_try(m_base - 1);
         io_try(m_lim + 1);
      end
      // second reset in mid-run restores every default
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      model_rst;
      @(posedge hclk);
      read_all;
      io_try(4'h0);
      end_of_test;
   end
endmodule

`default_nettype wire
